// File: hdl/nsc_params.svh
// Constants for the flash target sideband control block
// How it works
// - One data bus width, eight or sixteen bits, shared by every target.
// - With a double-rate interface enabled only eight-bit width is used.
// - Sixteen-bit bus: data uses full width, command and address low byte.
// - Command cycles ignore the upper data byte entirely.
// - Ready/busy line valid within 10 us plain, 250 us managed.
// - Ready/busy reports ready within 1 ms plain, 2 ms managed.
// - Ready/busy is open drain, only pulled low for busy.
// - Ready/busy equals AND of all LUN idle flags of the target.
// - Write-protect low refuses every program and erase operation.
// - Write-protect changes asynchronous to the interface clock are accepted.
// - Each target stays in low-power start-up until reset command FFh.
// - Each shared ready/busy line reads busy if either target is busy.
`ifndef NSC_PARAMS_SVH
`define NSC_PARAMS_SVH

// ----------------------------------------------------------------------
// Register map
// ----------------------------------------------------------------------
`define NSC_REG_CTRL      12'h000
`define NSC_REG_STATUS    12'h004
`define NSC_REG_ERROR     12'h008
`define NSC_REG_LASTCMD   12'h00c
`define NSC_REG_STARTUP   12'h010

`define NSC_CTRL_WIDE     0
`define NSC_CTRL_DDR      1
`define NSC_CTRL_DDR2     2
`define NSC_CTRL_RESET    3'h0

`define NSC_ERR_ADDR_HI   0
`define NSC_ERR_PROT      1
`define NSC_ERR_SETTLE    2
`define NSC_ERR_WP_BUSY   3
`define NSC_ERR_W         4

// ----------------------------------------------------------------------
// Opcodes
// ----------------------------------------------------------------------
`define NSC_OP_RESET      8'hff
`define NSC_OP_PROG_GO    8'h10
`define NSC_OP_ERASE_GO   8'hd0

// ----------------------------------------------------------------------
// Timing, in printed units, and clock rate
// ----------------------------------------------------------------------
`define NSC_CLK_MHZ           25
`define NSC_VALID_US_PLAIN    10
`define NSC_VALID_US_MANAGED  250
`define NSC_READY_MS_PLAIN    1
`define NSC_READY_MS_MANAGED  2
`define NSC_SETTLE_NS         100

`endif

// File: hdl/nsc_pkg.sv
// Types shared by the flash target sideband control block
package nsc_pkg;

    typedef enum logic [2:0] {
        NSC_PO_WAIT = 3'b001,
        NSC_PO_BUSY = 3'b010,
        NSC_PO_DONE = 3'b100
    } nsc_po_e;

    typedef logic [7:0] nsc_byte_t;

endpackage

// File: hdl/nsc_wp_sync.sv
// Write-protect synchroniser with change pulse
`timescale 1ns/1ps
`default_nettype none
module nsc_wp_sync
    import nsc_pkg::*;
(
    input  wire logic core_clk,
    input  wire logic reset,
    input  wire logic wp_async_n,
    output logic      wp_n,
    output logic      wp_change
);

    logic meta;
    logic wp_d;

    // Two stages; the first one feeds nothing but the second.
    // Reset to the pin's idle level, so release shows no false change
    always_ff @(posedge core_clk) begin
        if (reset) begin
            meta <= 1'b1;
            wp_n <= 1'b1;
        end else begin
            meta <= wp_async_n;
            wp_n <= meta;
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            wp_d      <= 1'b1;
            wp_change <= 1'b0;
        end else begin
            wp_d      <= wp_n;
            wp_change <= wp_d ^ wp_n;
        end
    end

endmodule
`default_nettype wire

// File: hdl/nsc_top.sv
// Sideband control of a flash target: bus width, ready/busy, protect, start-up
//
// Implementation choices: the APB slave port and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "nsc_params.svh"
module nsc_top
    import nsc_pkg::*;
#(
    parameter int TARGETS    = 8,
    parameter int LUNS       = 2,
    parameter bit MANAGED    = 1'b0,
    parameter int VALID_CYC  = (MANAGED ? `NSC_VALID_US_MANAGED
                                        : `NSC_VALID_US_PLAIN) * `NSC_CLK_MHZ,
    parameter int READY_CYC  = (MANAGED ? `NSC_READY_MS_MANAGED
                                        : `NSC_READY_MS_PLAIN)
                               * 1000 * `NSC_CLK_MHZ,
    parameter int SETTLE_CYC = (`NSC_SETTLE_NS * `NSC_CLK_MHZ + 999) / 1000
)(
    input  wire logic                    core_clk,
    input  wire logic                    reset,
    // APB slave
    input  wire logic                    psel,
    input  wire logic                    penable,
    input  wire logic                    pwrite,
    input  wire logic [11:0]             paddr,
    input  wire logic [31:0]             pwdata,
    output logic      [31:0]             prdata,
    output logic                         pready,
    output logic                         pslverr,
    // Host bus cycles
    input  wire logic [TARGETS-1:0]      select_line_n,
    input  wire logic                    cmd_latch,
    input  wire logic                    addr_latch,
    input  wire logic                    data_strobe,
    input  wire logic [15:0]             bus_in,
    input  wire logic                    wp_in_n,
    // Array side
    input  wire logic [TARGETS*LUNS-1:0] lun_idle_flag,
    output logic                         cmd_valid,
    output logic      [7:0]              cmd_code,
    output logic      [TARGETS-1:0]      cmd_targets,
    output logic                         addr_valid,
    output logic      [7:0]              addr_byte,
    output logic                         data_valid,
    output logic      [15:0]             data_word,
    output logic                         prog_go,
    output logic                         erase_go,
    output logic      [TARGETS-1:0]      startup_current_limit,
    // Shared open-drain ready/busy lines
    output logic      [TARGETS/2-1:0]    shared_idle_line,
    output logic      [TARGETS/2-1:0]    shared_idle_line_oe_n
);

    localparam int LINES = TARGETS / 2;
    localparam int PO_W  = $clog2(READY_CYC + 1);
    localparam int ST_W  = $clog2(SETTLE_CYC + 1);

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    function automatic logic target_idle(input logic [TARGETS*LUNS-1:0] f,
                                         input int t);
        logic r;
        r = 1'b1;
        for (int l = 0; l < LUNS; l++) begin
            r = r & f[t*LUNS+l];
        end
        return r;
    endfunction

    function automatic logic all_idle(input logic [TARGETS*LUNS-1:0] f);
        return &f;
    endfunction

    // ------------------------------------------------------------------
    // Write-protect synchroniser
    // ------------------------------------------------------------------
    logic wp_n;
    logic wp_change;

    nsc_wp_sync u_wp_sync (
        .core_clk   (core_clk),
        .reset      (reset),
        .wp_async_n (wp_in_n),
        .wp_n       (wp_n),
        .wp_change  (wp_change)
    );

    // ------------------------------------------------------------------
    // Configuration and width selection
    // ------------------------------------------------------------------
    logic [2:0] ctrl;
    logic       wide;
    logic       apb_wr;
    logic       apb_rd;
    logic       access;

    assign access = psel && penable && !pready;
    // Writes land on the edge that completes the transfer
    assign apb_wr = psel && penable && pready && pwrite;
    assign apb_rd = access && !pwrite;

    always_ff @(posedge core_clk) begin
        if (reset) begin
            ctrl <= `NSC_CTRL_RESET;
        end else if (apb_wr && paddr == `NSC_REG_CTRL) begin
            ctrl <= pwdata[2:0];
        end
    end

    // One width for all targets; double-rate modes force eight bits
    always_ff @(posedge core_clk) begin
        if (reset) begin
            wide <= 1'b0;
        end else begin
            wide <= ctrl[`NSC_CTRL_WIDE] && !ctrl[`NSC_CTRL_DDR]
                    && !ctrl[`NSC_CTRL_DDR2];
        end
    end

    // ------------------------------------------------------------------
    // Command, address and data cycles
    // ------------------------------------------------------------------
    logic [TARGETS-1:0] selected;
    assign selected = ~select_line_n;

    always_ff @(posedge core_clk) begin
        if (reset) begin
            cmd_valid   <= 1'b0;
            cmd_code    <= 8'h00;
            cmd_targets <= '0;
        end else begin
            cmd_valid <= cmd_latch && (|selected);
            if (cmd_latch) begin
                cmd_code    <= bus_in[7:0];
                cmd_targets <= selected;
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            addr_valid <= 1'b0;
            addr_byte  <= 8'h00;
        end else begin
            addr_valid <= addr_latch && (|selected);
            if (addr_latch) begin
                addr_byte <= bus_in[7:0];
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            data_valid <= 1'b0;
            data_word  <= 16'h0000;
        end else begin
            data_valid <= data_strobe && (|selected);
            if (data_strobe) begin
                data_word <= wide ? bus_in
                                  : {8'h00, bus_in[7:0]};
            end
        end
    end

    // ------------------------------------------------------------------
    // Program and erase gating by write-protect
    // ------------------------------------------------------------------
    logic is_prog;
    logic is_erase;
    logic cmd_take;

    assign cmd_take = cmd_latch && (|selected);
    assign is_prog  = cmd_take && bus_in[7:0] == `NSC_OP_PROG_GO;
    assign is_erase = cmd_take && bus_in[7:0] == `NSC_OP_ERASE_GO;

    // Protect level is the synchronised one, read at the moment of start
    always_ff @(posedge core_clk) begin
        if (reset) begin
            prog_go  <= 1'b0;
            erase_go <= 1'b0;
        end else begin
            prog_go  <= is_prog && wp_n;
            erase_go <= is_erase && wp_n;
        end
    end

    // ------------------------------------------------------------------
    // Low-power start-up per target
    // ------------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (reset) begin
            startup_current_limit <= '1;
        end else if (cmd_take && bus_in[7:0] == `NSC_OP_RESET) begin
            startup_current_limit <= startup_current_limit & ~selected;
        end
    end

    // ------------------------------------------------------------------
    // Power-on sequencing of ready/busy
    // ------------------------------------------------------------------
    nsc_po_e         po_state;
    logic [PO_W-1:0] po_count;

    always_ff @(posedge core_clk) begin
        if (reset) begin
            po_count <= '0;
        end else if (po_state != NSC_PO_DONE) begin
            po_count <= po_count + PO_W'(1);
        end
    end

    // Line released until valid, then held busy until the ready limit
    always_ff @(posedge core_clk) begin
        if (reset) begin
            po_state <= NSC_PO_WAIT;
        end else begin
            case (po_state)
                NSC_PO_WAIT: begin
                    if (po_count >= PO_W'(VALID_CYC - 2)) begin
                        po_state <= NSC_PO_BUSY;
                    end
                end
                NSC_PO_BUSY: begin
                    if (po_count >= PO_W'(READY_CYC - 2)) begin
                        po_state <= NSC_PO_DONE;
                    end
                end
                NSC_PO_DONE: begin
                    po_state <= NSC_PO_DONE;
                end
                default: begin
                    po_state <= NSC_PO_WAIT;
                end
            endcase
        end
    end

    // Value bit is constant low; only the enable moves, so the pin never
    // drives a high level against the pull-up
    always_ff @(posedge core_clk) begin
        if (reset) begin
            shared_idle_line      <= '0;
            shared_idle_line_oe_n <= '1;
        end else begin
            shared_idle_line <= '0;
            for (int j = 0; j < LINES; j++) begin
                case (po_state)
                    NSC_PO_WAIT: shared_idle_line_oe_n[j] <= 1'b1;
                    NSC_PO_BUSY: shared_idle_line_oe_n[j] <= 1'b0;
                    default: shared_idle_line_oe_n[j] <=
                        target_idle(lun_idle_flag, j)
                        && target_idle(lun_idle_flag, j + LINES);
                endcase
            end
        end
    end

    // ------------------------------------------------------------------
    // Host-side checks on address cycles, protect and protect changes
    // ------------------------------------------------------------------
    logic [ST_W-1:0] settle;

    always_ff @(posedge core_clk) begin
        if (reset) begin
            settle <= '0;
        end else if (wp_change) begin
            settle <= ST_W'(SETTLE_CYC);
        end else if (settle != '0) begin
            settle <= settle - ST_W'(1);
        end
    end

    logic [`NSC_ERR_W-1:0] err;
    logic [`NSC_ERR_W-1:0] err_set;
    logic [`NSC_ERR_W-1:0] err_clr;

    always_comb begin
        err_set = '0;
        err_set[`NSC_ERR_ADDR_HI] = addr_latch && wide
                                    && bus_in[15:8] != 8'h00;
        err_set[`NSC_ERR_PROT]    = (is_prog || is_erase) && !wp_n;
        err_set[`NSC_ERR_SETTLE]  = cmd_take && settle != '0;
        err_set[`NSC_ERR_WP_BUSY] = wp_change
                                    && !all_idle(lun_idle_flag);
    end

    assign err_clr = (apb_wr && paddr == `NSC_REG_ERROR)
                     ? pwdata[`NSC_ERR_W-1:0] : '0;

    // A new event in the clearing cycle survives
    always_ff @(posedge core_clk) begin
        if (reset) begin
            err <= '0;
        end else begin
            err <= (err & ~err_clr) | err_set;
        end
    end

    // ------------------------------------------------------------------
    // APB read path and answer
    // ------------------------------------------------------------------
    logic [31:0] rd_mux;
    logic        rd_bad;

    always_comb begin
        rd_mux = 32'h0000_0000;
        rd_bad = 1'b0;
        if (paddr == `NSC_REG_CTRL) begin
            rd_mux = {29'h0, ctrl};
        end else if (paddr == `NSC_REG_STATUS) begin
            rd_mux = {25'h0, wide, wp_n, settle != '0,
                      all_idle(lun_idle_flag), po_state};
        end else if (paddr == `NSC_REG_ERROR) begin
            rd_mux = {{(32-`NSC_ERR_W){1'b0}}, err};
        end else if (paddr == `NSC_REG_LASTCMD) begin
            rd_mux = {24'h0, cmd_code};
        end else if (paddr == `NSC_REG_STARTUP) begin
            rd_mux = 32'(startup_current_limit);
        end else begin
            rd_bad = 1'b1;
        end
    end

    // One wait state: pready rises the cycle after the access phase opens
    always_ff @(posedge core_clk) begin
        if (reset) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end else begin
            pready  <= access;
            pslverr <= access && rd_bad;
            if (apb_rd && !rd_bad) begin
                prdata <= rd_mux;
            end else if (access) begin
                prdata <= 32'h0000_0000;
            end
        end
    end

endmodule
`default_nettype wire

// File: dv/nsc_top_sva.sv
// Assertion checker for the flash target sideband control block
`timescale 1ns/1ps
`default_nettype none
module nsc_top_chk #(
    parameter int TARGETS   = 8,
    parameter int LUNS      = 2,
    parameter int VALID_CYC = 4,
    parameter int READY_CYC = 10
)(
    input wire logic                    core_clk,
    input wire logic                    reset,
    input wire logic [TARGETS-1:0]      select_line_n,
    input wire logic                    cmd_latch,
    input wire logic                    addr_latch,
    input wire logic                    data_strobe,
    input wire logic [15:0]             bus_in,
    input wire logic                    wp_in_n,
    input wire logic [TARGETS*LUNS-1:0] lun_idle_flag,
    input wire logic                    cmd_valid,
    input wire logic [7:0]              cmd_code,
    input wire logic                    addr_valid,
    input wire logic [7:0]              addr_byte,
    input wire logic                    data_valid,
    input wire logic [15:0]             data_word,
    input wire logic                    prog_go,
    input wire logic                    erase_go,
    input wire logic [TARGETS-1:0]      startup_current_limit,
    input wire logic [TARGETS/2-1:0]    shared_idle_line,
    input wire logic [TARGETS/2-1:0]    shared_idle_line_oe_n
);
    // ----
    // Helpers
    // ----
    int                   up_cnt;
    logic [TARGETS/2-1:0] exp_oe_n;
    wire logic            any_sel = |(~select_line_n);

    // Saturates so it never wraps during a long run
    always_ff @(posedge core_clk) begin
        if (reset) begin
            up_cnt <= 0;
        end else if (up_cnt < READY_CYC + 8) begin
            up_cnt <= up_cnt + 1;
        end
    end

    always_comb begin
        for (int j = 0; j < TARGETS/2; j++) begin
            exp_oe_n[j] = (&lun_idle_flag[j*LUNS +: LUNS])
                        & (&lun_idle_flag[(j+TARGETS/2)*LUNS +: LUNS]);
        end
    end

    default clocking @(posedge core_clk); endclocking
    default disable iff (reset);

    // ----
    // Properties
    // ----
    property p_cmd;
        cmd_latch && any_sel |=> cmd_valid && cmd_code == $past(bus_in[7:0]);
    endproperty
    a_cmd: assert property (p_cmd)
        else $error("command byte wrong");

    property p_addr;
        addr_latch && any_sel |=> addr_valid
                                  && addr_byte == $past(bus_in[7:0]);
    endproperty
    a_addr: assert property (p_addr)
        else $error("address byte wrong");

    property p_data;
        data_strobe && any_sel |=> data_valid
                                   && data_word[7:0] == $past(bus_in[7:0]);
    endproperty
    a_data: assert property (p_data)
        else $error("data low byte wrong");

    property p_drain;
        shared_idle_line == '0;
    endproperty
    a_drain: assert property (p_drain)
        else $error("ready line driven high");

    property p_busy;
        up_cnt > VALID_CYC + 1 && up_cnt < READY_CYC - 1
            |-> shared_idle_line_oe_n == '0;
    endproperty
    a_busy: assert property (p_busy)
        else $error("ready line not busy after valid delay");

    property p_ready;
        up_cnt >= READY_CYC + 3 && $stable(lun_idle_flag)
            && $past(lun_idle_flag, 2) == lun_idle_flag
            |-> shared_idle_line_oe_n == exp_oe_n;
    endproperty
    a_ready: assert property (p_ready)
        else $error("ready line not the idle AND");

    property p_lock;
        !wp_in_n [*8] |=> !prog_go && !erase_go;
    endproperty
    a_lock: assert property (p_lock)
        else $error("array change while protected");

    property p_go;
        prog_go || erase_go
            |-> cmd_valid && cmd_code == (prog_go ? 8'h10 : 8'hd0);
    endproperty
    a_go: assert property (p_go)
        else $error("start pulse without its command");

    property p_start;
        cmd_latch && bus_in[7:0] == 8'hff
            |=> (startup_current_limit & ~$past(select_line_n)) == '0;
    endproperty
    a_start: assert property (p_start)
        else $error("start-up limit kept after reset command");

    property p_keep;
        (startup_current_limit & ~$past(startup_current_limit)) == '0;
    endproperty
    a_keep: assert property (p_keep)
        else $error("start-up limit came back");

    c_prog: cover property (prog_go);
    c_erase: cover property (erase_go);
    c_ready: cover property (up_cnt >= READY_CYC + 3
                             && shared_idle_line_oe_n != '1);
endmodule

bind nsc_top nsc_top_chk #(
    .TARGETS(TARGETS), .LUNS(LUNS),
    .VALID_CYC(VALID_CYC), .READY_CYC(READY_CYC)
) i_chk (
    .core_clk(core_clk), .reset(reset), .select_line_n(select_line_n),
    .cmd_latch(cmd_latch), .addr_latch(addr_latch),
    .data_strobe(data_strobe), .bus_in(bus_in), .wp_in_n(wp_in_n),
    .lun_idle_flag(lun_idle_flag), .cmd_valid(cmd_valid),
    .cmd_code(cmd_code), .addr_valid(addr_valid), .addr_byte(addr_byte),
    .data_valid(data_valid), .data_word(data_word), .prog_go(prog_go),
    .erase_go(erase_go), .startup_current_limit(startup_current_limit),
    .shared_idle_line(shared_idle_line),
    .shared_idle_line_oe_n(shared_idle_line_oe_n)
);
`default_nettype wire

// File: dv/nsc_host_model.sv
// Behavioural host controller driving the target's bus cycles
`timescale 1ns/1ps
`default_nettype none
module nsc_host_model (
    input  wire logic        core_clk,
    output var  logic [7:0]  select_line_n,
    output var  logic        cmd_latch,
    output var  logic        addr_latch,
    output var  logic        data_strobe,
    output var  logic [15:0] bus_in,
    output var  logic        wp_in_n
);
    initial begin
        select_line_n = 8'hff;
        {cmd_latch, addr_latch, data_strobe} = 3'h0;
        bus_in = 16'h0;
        wp_in_n = 1'b1;
    end

    // Kind 0 command, 1 address, 2 data; target 8 selects nobody
    task automatic cycle(input int kind, input int tgt,
                         input logic [15:0] v);
        @(posedge core_clk);
        select_line_n <= ~(8'h01 << tgt);
        cmd_latch <= (kind == 0);
        addr_latch <= (kind == 1);
        data_strobe <= (kind == 2);
        bus_in <= (kind == 1) ? {8'h00, v[7:0]} : v;
        @(posedge core_clk);
        {cmd_latch, addr_latch, data_strobe} <= 3'h0;
        select_line_n <= 8'hff;
        // Released bus shows garbage, not the last value
        bus_in <= ~bus_in;
    endtask

    task automatic set_wp(input logic v);
        @(posedge core_clk);
        wp_in_n <= v;
        repeat (12) @(posedge core_clk);
    endtask
endmodule
`default_nettype wire

// File: dv/nand_target_sideband_control_test.sv
// Self-checking testbench for the flash target sideband control block
`timescale 1ns/1ps
`default_nettype none
module nand_target_sideband_control_test;
    localparam int VLD = 4;
    localparam int RDY = 10;
    logic        core_clk = 1'b0;
    logic        reset = 1'b1;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [11:0] paddr = 12'h0;
    logic [31:0] pwdata = 32'h0;
    logic [15:0] lun_idle_flag = 16'hffff;
    logic [31:0] rdata;
    logic        rerr;
    int          bad_count = 0;
    int          num_checks = 0;
    int          cycles = 0;
    wire logic [31:0] prdata;
    wire logic        pready, pslverr, cmd_latch, addr_latch, data_strobe;
    wire logic        wp_in_n, cmd_valid, addr_valid, data_valid;
    wire logic        prog_go, erase_go;
    wire logic [7:0]  select_line_n, cmd_code, addr_byte, cmd_targets;
    wire logic [7:0]  startup_current_limit;
    wire logic [15:0] bus_in, data_word;
    wire logic [3:0]  shared_idle_line, shared_idle_line_oe_n;
    // Open drain with pull-up: released reads high
    wire logic [3:0]  rb_wire = shared_idle_line_oe_n | shared_idle_line;
    logic [31:0] ctrl_tab [4] = '{32'h0, 32'h1, 32'h3, 32'h5};
    logic [15:0] word_tab [4] = '{16'h00ef, 16'hbeef, 16'h00ef, 16'h00ef};

    nsc_host_model host (
        .core_clk(core_clk), .select_line_n(select_line_n),
        .cmd_latch(cmd_latch), .addr_latch(addr_latch),
        .data_strobe(data_strobe), .bus_in(bus_in), .wp_in_n(wp_in_n)
    );

    nsc_top #(.VALID_CYC(VLD), .READY_CYC(RDY)) i_dut (
        .core_clk(core_clk), .reset(reset), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .select_line_n(select_line_n),
        .cmd_latch(cmd_latch), .addr_latch(addr_latch),
        .data_strobe(data_strobe), .bus_in(bus_in), .wp_in_n(wp_in_n),
        .lun_idle_flag(lun_idle_flag), .cmd_valid(cmd_valid),
        .cmd_code(cmd_code), .cmd_targets(cmd_targets),
        .addr_valid(addr_valid),
        .addr_byte(addr_byte), .data_valid(data_valid),
        .data_word(data_word), .prog_go(prog_go), .erase_go(erase_go),
        .startup_current_limit(startup_current_limit),
        .shared_idle_line(shared_idle_line),
        .shared_idle_line_oe_n(shared_idle_line_oe_n)
    );

    initial begin
        forever #20 core_clk = ~core_clk;
    end

    // ----
    // Tasks
    // ----
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        @(posedge core_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        @(posedge core_clk);
        while (pready !== 1'b1) @(posedge core_clk);
        rdata = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic finish_test();
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // The whole sequence needs well under a thousand cycles
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 3000) begin
            bad_count++;
            finish_test();
        end
    end

    // ----
    // Sequence
    // ----
    initial begin
        repeat (16) @(posedge core_clk);
        reset <= 1'b0;
        @(negedge core_clk);
        check(32'(rb_wire), 32'hf);
        check(32'(startup_current_limit), 32'hff);
        repeat (VLD + 3) @(posedge core_clk);
        @(negedge core_clk);
        check(32'(rb_wire), 32'h0);
        repeat (RDY - VLD + 1) @(posedge core_clk);
        @(negedge core_clk);
        check(32'(rb_wire), 32'hf);
        apb(1'b0, 12'h004, 32'h0);
        check(rdata, 32'h2c);
        apb(1'b0, 12'h014, 32'h0);
        check({rdata[30:0], rerr}, 32'h1);
        host.cycle(0, 3, 16'h12ff);
        @(negedge core_clk);
        check(32'({cmd_valid, cmd_code, startup_current_limit}), 32'h1fff7);
        check(32'(cmd_targets), 32'h08);
        host.cycle(0, 8, 16'h00ff);
        @(negedge core_clk);
        check(32'({cmd_valid, startup_current_limit}), 32'hf7);
        apb(1'b0, 12'h010, 32'h0);
        check(rdata, 32'hf7);
        for (int t = 0; t < 8; t++) begin
            @(posedge core_clk);
            lun_idle_flag <= ~(16'h0001 << (2 * t + t % 2));
            repeat (4) @(posedge core_clk);
            @(negedge core_clk);
            check(32'(rb_wire), 32'(4'(~(4'h1 << (t % 4)))));
        end
        @(posedge core_clk);
        lun_idle_flag <= 16'hffff;
        for (int i = 0; i < 4; i++) begin
            apb(1'b1, 12'h000, ctrl_tab[i]);
            host.cycle(2, 0, 16'hbeef);
            @(negedge core_clk);
            check(32'({data_valid, data_word}), 32'({1'b1, word_tab[i]}));
        end
        apb(1'b1, 12'h000, 32'h1);
        host.cycle(1, 0, 16'h0034);
        @(negedge core_clk);
        check(32'({addr_valid, addr_byte}), 32'h134);
        host.cycle(0, 2, 16'h5a10);
        @(negedge core_clk);
        check(32'({prog_go, cmd_code}), 32'h110);
        host.set_wp(1'b0);
        host.cycle(0, 1, 16'h00d0);
        @(negedge core_clk);
        check(32'({erase_go, cmd_valid}), 32'h1);
        apb(1'b0, 12'h008, 32'h0);
        check(32'(rdata[1]), 32'h1);
        apb(1'b1, 12'h008, 32'h2);
        apb(1'b0, 12'h008, 32'h0);
        check(32'(rdata[1]), 32'h0);
        host.set_wp(1'b1);
        host.cycle(0, 1, 16'h00d0);
        @(negedge core_clk);
        check(32'(erase_go), 32'h1);
        finish_test();
    end
endmodule
`default_nettype wire
